// file: hw/imes_pkg.sv
// Shared constants and types for the EEPROM sequencing two-wire master.
// Assumes a 200 MHz system clock and a separate timeout reference clock.
package imes_pkg;

    // ------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int BIT_RATE_HZ = 400_000;
    // Four quarters per bit cell
    localparam int QTR_CYC = SYS_CLK_HZ / (4 * BIT_RATE_HZ);
    localparam int QW = $clog2(QTR_CYC);

    // ------------------------------------------------------------
    // Low-clock timeout
    // ------------------------------------------------------------
    localparam real TOUT_MS = 5.24288;
    localparam int REF_CLK_HZ = 12_500_000;
    localparam int TOUT_W = 16;
    localparam int TOUT_CYC = int'(TOUT_MS * REF_CLK_HZ / 1000.0);

    // ------------------------------------------------------------
    // Target address byte: bits 7..3 fixed, 2..1 straps, 0 direction
    // ------------------------------------------------------------
    localparam logic [4:0] DEV_TYPE = 5'h14;
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ = 1'h1;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] LAST_DBIT = 4'h7;

    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_POLL} imes_op_e;
    typedef enum logic [2:0] {PH_IDLE, PH_START, PH_LOAD, PH_BYTE, PH_STOP} imes_ph_e;
    typedef enum logic [2:0] {
        K_ADDR_W, K_MEM_HI, K_MEM_LO, K_DATA_W, K_ADDR_R, K_DATA_R
    } imes_kind_e;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_NACK, ST_FAIL} imes_st_e;

endpackage : imes_pkg

// file: hw/imes_top.sv
// Two-wire master that sequences EEPROM byte write, random read and
// acknowledge polling. Assumes open-drain pins resolved outside and a
// free-running timeout reference clock.
// Functional notes
// R1: Write starts with start condition, then target address with direction bit 0.
// R2: After address, send memory location as two bytes, then data bytes in order.
// R3: After last written byte, generate stop and release the bus.
// R4: Random read begins start, address with bit 0, two location bytes.
// R5: After location bytes, repeated start and address with direction bit 1.
// R6: Master keeps clocking after read address; target drives data on those clocks.
// R7: Acknowledge every received byte except the final one.
// R8: Final received byte gets not-acknowledge, then a stop condition.
// R9: Poll probe is start, target address, stop; no location or data.
// R10: Target answers not-acknowledge while writing internally, acknowledge when done.
// R11: Address byte holds direction in bit 0, straps in bits 1 and 2.
// R12: Timeout counts only while clock line low, 16-bit counter on reference clock.
// R13: Start, stop, not-acknowledge, arbitration lost, timeout raise shared event.
// R14: Separate requests for receive data, transmit empty and transfer complete.
// R15: Timeout or arbitration loss makes the master generate a stop.
// R16: Stop seen before a transfer ends sets status to failure.
// R17: No new transfer while the bus is busy or one is running.
// R18: All bytes shift most significant bit first.
`timescale 1ns/10ps
module imes_top
    import imes_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter logic [TOUT_W-1:0] TOUT_LIM = TOUT_W'(TOUT_CYC - 1)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic ref_clk,
    input wire logic cmd_valid,
    input imes_op_e cmd_op,
    input wire logic [15:0] cmd_mem_addr,
    input wire logic [CNT_W-1:0] cmd_count,
    output logic cmd_refused,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic xfer_done,
    output imes_st_e status,
    output logic bus_busy,
    output logic evt_start,
    output logic evt_stop,
    output logic evt_nack,
    output logic evt_al,
    output logic evt_timeout,
    output logic err_evt,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    input wire logic scl_sense,
    output logic scl_drv,
    output logic scl_oe,
    input wire logic sda_sense,
    output logic sda_drv,
    output logic sda_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sy_scl;
        logic [1:0] sy_sda;
        logic [1:0] sy_s0;
        logic [1:0] sy_s1;
        logic [1:0] sy_to;
        logic sda_p;
        logic to_p;
        imes_ph_e ph;
        imes_kind_e kind;
        imes_op_e op;
        logic rs;
        logic [1:0] qq;
        logic [QW-1:0] qcnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic samp;
        logic [15:0] mem;
        logic [CNT_W-1:0] cnt;
        logic busy;
        imes_st_e st;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rxd;
        logic rxv;
        logic done;
        logic refd;
        logic e_st;
        logic e_sp;
        logic e_nk;
        logic e_al;
        logic e_to;
        logic err;
    } imes_sys_s;

    typedef struct packed {
        logic [1:0] sy_scl;
        logic [TOUT_W-1:0] cnt;
        logic fired;
        logic tog;
    } imes_ref_s;

    imes_sys_s q;
    imes_sys_s d;
    imes_ref_s r;
    imes_ref_s rd;

    logic start_det;
    logic stop_det;
    logic tout_ev;
    logic tick;
    logic run;
    logic stretch;
    logic active;

    // ------------------------------------------------------------
    // Bus monitor and timer terms
    // ------------------------------------------------------------
    assign start_det = q.sy_scl[1] && q.sda_p && !q.sy_sda[1];
    assign stop_det = q.sy_scl[1] && !q.sda_p && q.sy_sda[1];
    assign tout_ev = q.sy_to[1] ^ q.to_p;
    assign tick = (q.qcnt == QW'(QTR_CYC - 1));
    // Target may hold the clock low; wait in the first high quarter
    assign stretch = (q.qq == 2'h2) && !q.sy_scl[1];
    assign run = (q.ph != PH_IDLE) && (q.ph != PH_LOAD) && !stretch;
    assign active = (q.ph != PH_IDLE) && (q.ph != PH_STOP);

    // ------------------------------------------------------------
    // System domain next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sy_scl = {q.sy_scl[0], scl_sense};
        d.sy_sda = {q.sy_sda[0], sda_sense};
        d.sy_s0 = {q.sy_s0[0], addr_strap_low};
        d.sy_s1 = {q.sy_s1[0], addr_strap_high};
        d.sy_to = {q.sy_to[0], r.tog};
        d.sda_p = q.sy_sda[1];
        d.to_p = q.sy_to[1];
        d.rxv = 1'h0;
        d.done = 1'h0;
        d.refd = 1'h0;
        d.e_nk = 1'h0;
        d.e_al = 1'h0;
        d.e_st = start_det; // R13
        d.e_sp = stop_det; // R13
        d.e_to = tout_ev; // R13
        if (start_det) begin
            d.busy = 1'h1;
        end
        if (stop_det) begin
            d.busy = 1'h0;
        end
        if (run) begin
            d.qcnt = tick ? '0 : q.qcnt + 1'h1;
            if (tick) begin
                d.qq = q.qq + 2'h1;
            end
        end
        // Pin drive; data only moves in the second low quarter
        unique case (q.ph)
            PH_IDLE: begin
                d.scl_oe = 1'h0;
                d.sda_oe = 1'h0;
            end
            PH_START: begin
                d.scl_oe = q.rs && (q.qq < 2'h2);
                d.sda_oe = (q.qq == 2'h3) || ((q.qq == 2'h0) && q.sda_oe);
            end
            PH_LOAD: begin
                d.scl_oe = 1'h1;
            end
            PH_BYTE: begin
                d.scl_oe = (q.qq < 2'h2); // R6
                if (q.qq != 2'h0) begin
                    if (q.bitn == ACK_BIT) begin
                        d.sda_oe = (q.kind == K_DATA_R) && (q.cnt != CNT_W'(1)); // R7 R8
                    end else begin
                        d.sda_oe = (q.kind != K_DATA_R) && !q.sh[7]; // R18
                    end
                end
            end
            PH_STOP: begin
                d.scl_oe = (q.qq < 2'h2);
                if (q.qq != 2'h0) begin
                    d.sda_oe = (q.qq != 2'h3); // R3
                end
            end
        endcase
        unique case (q.ph)
            PH_IDLE: begin
                if (cmd_valid) begin
                    if (q.busy || ((cmd_op == OP_READ) && (cmd_count == '0))) begin
                        d.refd = 1'h1; // R17
                    end else begin
                        d.ph = PH_START; // R1 R4 R9
                        d.rs = 1'h0;
                        d.op = cmd_op;
                        d.mem = cmd_mem_addr;
                        d.cnt = cmd_count;
                        d.kind = K_ADDR_W;
                        d.st = ST_BUSY;
                        d.qq = 2'h0;
                        d.qcnt = '0;
                    end
                end
            end
            PH_START: begin
                if (tick && (q.qq == 2'h3)) begin
                    d.ph = PH_LOAD;
                end
            end
            PH_LOAD: begin
                d.bitn = 4'h0;
                d.ph = PH_BYTE;
                unique case (q.kind)
                    K_ADDR_W: d.sh = {DEV_TYPE, q.sy_s1[1], q.sy_s0[1], RW_WRITE}; // R1 R11
                    K_MEM_HI: d.sh = q.mem[15:8]; // R2
                    K_MEM_LO: d.sh = q.mem[7:0]; // R2
                    K_ADDR_R: d.sh = {DEV_TYPE, q.sy_s1[1], q.sy_s0[1], RW_READ}; // R5 R11
                    K_DATA_R: d.sh = 8'h00;
                    K_DATA_W: begin
                        // Clock held low until the source has a byte
                        d.sh = tx_data;
                        d.ph = (tx_valid && clk_en) ? PH_BYTE : PH_LOAD; // R14
                    end
                    default: d.ph = PH_STOP;
                endcase
            end
            PH_BYTE: begin
                if (tick && (q.qq == 2'h2)) begin
                    d.samp = q.sy_sda[1];
                    if ((q.bitn < ACK_BIT) && (q.kind != K_DATA_R) && q.sh[7]
                        && !q.sy_sda[1]) begin
                        d.e_al = 1'h1; // R13
                        d.st = ST_FAIL;
                        d.ph = PH_STOP; // R15
                        d.qq = 2'h0;
                        d.qcnt = '0;
                    end
                end
                if (tick && (q.qq == 2'h3)) begin
                    if (q.bitn != ACK_BIT) begin
                        d.sh = {q.sh[6:0], q.samp}; // R18
                        d.bitn = q.bitn + 4'h1;
                        if ((q.bitn == LAST_DBIT) && (q.kind == K_DATA_R)) begin
                            d.rxd = {q.sh[6:0], q.samp}; // R6
                            d.rxv = 1'h1; // R14
                        end
                    end else if (q.samp && (q.kind != K_DATA_R)) begin
                        d.e_nk = 1'h1; // R10 R13
                        d.st = ST_NACK;
                        d.ph = PH_STOP;
                    end else begin
                        d.ph = PH_LOAD;
                        unique case (q.kind)
                            K_ADDR_W: begin
                                if (q.op == OP_POLL) begin
                                    d.ph = PH_STOP; // R9
                                end else begin
                                    d.kind = K_MEM_HI; // R2 R4
                                end
                            end
                            K_MEM_HI: d.kind = K_MEM_LO;
                            K_MEM_LO: begin
                                if (q.op == OP_READ) begin
                                    d.kind = K_ADDR_R; // R5
                                    d.ph = PH_START;
                                    d.rs = 1'h1;
                                end else if (q.cnt == '0) begin
                                    d.ph = PH_STOP; // R3
                                end else begin
                                    d.kind = K_DATA_W;
                                end
                            end
                            K_ADDR_R: d.kind = K_DATA_R; // R6
                            default: begin
                                d.cnt = q.cnt - 1'h1;
                                if (q.cnt == CNT_W'(1)) begin
                                    d.ph = PH_STOP; // R3 R8
                                end
                            end
                        endcase
                    end
                end
            end
            PH_STOP: begin
                if (tick && (q.qq == 2'h3)) begin
                    d.ph = PH_IDLE;
                    d.done = 1'h1; // R14
                    if (q.st == ST_BUSY) begin
                        d.st = ST_IDLE;
                    end
                end
            end
        endcase
        // Abandon the transfer on a stuck low clock
        if (tout_ev && active) begin
            d.st = ST_FAIL;
            d.ph = PH_STOP; // R15
            d.qq = 2'h0;
            d.qcnt = '0;
        end
        // Someone else ended the frame under us
        if (stop_det && active) begin
            d.st = ST_FAIL; // R16
            d.ph = PH_IDLE;
        end
        d.err = d.e_st || d.e_sp || d.e_nk || d.e_al || d.e_to; // R13
        if (!clk_en) begin
            d = q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            // Lines idle high; a zero here would fake a stop edge
            q.sy_scl <= 2'h3;
            q.sy_sda <= 2'h3;
            q.sda_p <= 1'h1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Reference domain: low-clock timeout
    // ------------------------------------------------------------
    always_comb begin
        rd = r;
        rd.sy_scl = {r.sy_scl[0], scl_sense};
        if (r.sy_scl[1]) begin
            rd.cnt = '0; // R12
            rd.fired = 1'h0;
        end else if (!r.fired) begin
            if (r.cnt == TOUT_LIM) begin
                rd.fired = 1'h1;
                rd.tog = ~r.tog;
            end else begin
                rd.cnt = r.cnt + 1'h1; // R12
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.sy_scl <= 2'h3;
        end else begin
            r <= rd;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign scl_drv = 1'h0;
    assign sda_drv = 1'h0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign tx_ready = (q.ph == PH_LOAD) && (q.kind == K_DATA_W) && clk_en;
    assign rx_data = q.rxd;
    assign rx_valid = q.rxv;
    assign xfer_done = q.done;
    assign cmd_refused = q.refd;
    assign status = q.st;
    assign bus_busy = q.busy;
    assign evt_start = q.e_st;
    assign evt_stop = q.e_sp;
    assign evt_nack = q.e_nk;
    assign evt_al = q.e_al;
    assign evt_timeout = q.e_to;
    assign err_evt = q.err;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    addr_write_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
        (q.ph == PH_BYTE) && (q.kind == K_ADDR_W) && (q.bitn == 4'h0)
        |-> (q.sh[0] == RW_WRITE) && (q.sh[7:3] == DEV_TYPE))
        else $error("write address byte malformed");
    addr_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
        (q.ph == PH_BYTE) && (q.kind == K_ADDR_R) && (q.bitn == 4'h0)
        |-> (q.sh[0] == RW_READ) && q.rs)
        else $error("read address byte malformed");
    mem_high_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
        (q.ph == PH_BYTE) && (q.kind == K_MEM_HI) && (q.bitn == 4'h0)
        |-> (q.sh == q.mem[15:8]))
        else $error("memory high byte wrong");
    done_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
        $rose(q.done) |-> ($past(q.ph) == PH_STOP) && (q.ph == PH_IDLE))
        else $error("completion without stop");
    rx_ack_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
        (q.ph == PH_BYTE) && (q.kind == K_DATA_R) && (q.bitn == ACK_BIT)
        && (q.qq == 2'h2) && (q.cnt > CNT_W'(1)) |-> q.sda_oe)
        else $error("missing acknowledge on read byte");
    rx_nack_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        (q.ph == PH_BYTE) && (q.kind == K_DATA_R) && (q.bitn == ACK_BIT)
        && (q.qq == 2'h2) && (q.cnt == CNT_W'(1)) |-> !q.sda_oe)
        else $error("last read byte acknowledged");
    poll_short_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        (q.ph != PH_IDLE) && (q.op == OP_POLL) |-> (q.kind == K_ADDR_W))
        else $error("poll sent more than address");
    msb_first_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R18
        (q.ph == PH_BYTE) && (q.kind != K_DATA_R) && (q.bitn < ACK_BIT)
        && (q.qq == 2'h2) |-> (q.sda_oe == !q.sh[7]))
        else $error("bit order wrong");
    tout_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
        clk_en && tout_ev && active && !stop_det
        |=> (q.ph == PH_STOP) && (q.st == ST_FAIL))
        else $error("timeout did not force stop");
    fail_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
        clk_en && stop_det && active |=> (q.st == ST_FAIL) && (q.ph == PH_IDLE))
        else $error("early stop not flagged");
    refuse_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
        clk_en && cmd_valid && (q.ph == PH_IDLE) && q.busy
        |=> q.refd && (q.ph == PH_IDLE))
        else $error("start taken on busy bus");
    err_share_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
        q.err == (q.e_st || q.e_sp || q.e_nk || q.e_al || q.e_to))
        else $error("shared event mismatch");
    tout_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
        r.sy_scl[1] |=> (r.cnt == '0))
        else $error("timeout counted with clock high");

endmodule : imes_top

// file: verification/imes_eeprom_model.sv
// Behavioural two-wire EEPROM with a two-byte location pointer.
// Assumes resolved open-drain lines with pull-ups supplied by the bench.
`timescale 1ns/10ps
module imes_eeprom_model #(
    parameter logic [6:0] DEV_ADDR = 7'h53,
    parameter int BUSY_POLLS = 1
) (
    input wire logic scl,
    input wire logic sda,
    input int stretch_ns,
    output logic scl_pull,
    output logic sda_pull
);
    // ------------------------------------------------------------
    // State: m 0 addr, 1 loc high, 2 loc low, 3 write, 4 read, 5 idle
    // ------------------------------------------------------------
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [15:0] ptr;
    logic mack;
    logic wrote = 1'b0;
    int bc = 0;
    int m = 5;
    int busy = 0;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task take_byte();
        case (m)
            0: begin
                m = (sh[7:1] == DEV_ADDR && busy == 0) ? (sh[0] ? 4 : 1) : 5;
                if (busy > 0)
                    busy = busy - 1;
                mack = 1'b1;
            end
            1: begin
                ptr[15:8] = sh;
                m = 2;
            end
            2: begin
                ptr[7:0] = sh;
                m = 3;
            end
            default: begin
                mem[ptr[7:0]] = sh;
                ptr = ptr + 16'h0001;
                wrote = 1'b1;
            end
        endcase
        sda_pull = (m != 5);
    endtask : take_byte

    // ------------------------------------------------------------
    // Framing and bit handling
    // ------------------------------------------------------------
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bc = -1;
            m = 0;
            sda_pull = 1'b0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            if (wrote)
                busy = BUSY_POLLS;
            wrote = 1'b0;
            m = 5;
        end
    end

    always @(posedge scl) begin
        if (m != 4 && bc >= 0 && bc < 8)
            sh = {sh[6:0], sda};
        if (m == 4 && bc == 8)
            mack = !sda;
    end

    // Stretch only after the ack slot, where a slow part would hold off
    always @(negedge scl) begin
        if (m != 5) begin
            if (bc == 7) begin
                bc = 8;
                sda_pull = 1'b0;
                if (m != 4)
                    take_byte();
            end else if (bc == 8) begin
                bc = 0;
                sda_pull = 1'b0;
                if (m == 4 && mack) begin
                    sh = mem[ptr[7:0]];
                    ptr = ptr + 16'h0001;
                    sda_pull = !sh[7];
                end else if (m == 4)
                    m = 5;
                if (stretch_ns > 0) begin
                    scl_pull = 1'b1;
                    #(stretch_ns) scl_pull = 1'b0;
                end
            end else begin
                bc = bc + 1;
                if (m == 4)
                    sda_pull = !sh[7 - bc];
            end
        end
    end
endmodule : imes_eeprom_model

// file: verification/imes_top_bench.sv
// Self-checking bench for the EEPROM sequencing two-wire master.
// Assumes the behavioural EEPROM model and pull-ups on both lines.
`timescale 1ns/10ps
module imes_top_bench
    import imes_pkg::*;
    ;
    // ------------------------------------------------------------
    // Stimulus and wires
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic cmd_valid = 1'b0;
    imes_op_e cmd_op = OP_WRITE;
    logic [15:0] cmd_mem_addr = 16'h0000;
    logic [7:0] cmd_count = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic addr_strap_low = 1'b1;
    logic addr_strap_high = 1'b1;
    logic tb_scl_low = 1'b0;
    logic tb_sda_low = 1'b0;
    logic cmd_refused, tx_ready, rx_valid, xfer_done, bus_busy, scl_oe, sda_oe, m_scl, m_sda;
    logic evt_start, evt_stop, evt_nack, evt_al, evt_timeout, err_evt;
    logic [7:0] rx_data;
    imes_st_e status;
    logic [7:0] tx_q[$];
    logic [7:0] exp_q[$];
    int failures = 0;
    int num_checks = 0;
    int n_nack = 0;
    int n_to = 0;
    int stretch_ns = 0;
    logic [15:0] a;
    logic [7:0] d0, d1;
    // Open-drain resolution: any party pulling wins
    wire scl_sense = !(scl_oe || m_scl || tb_scl_low);
    wire sda_sense = !(sda_oe || m_sda || tb_sda_low);

    initial forever #2.5 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #3 ref_clk = ~ref_clk;
    end

    imes_top #(.TOUT_LIM(16'h03e8)) i_dut (
        .sys_clk, .nrst, .clk_en, .ref_clk, .cmd_valid, .cmd_op, .cmd_mem_addr, .cmd_count,
        .cmd_refused, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .xfer_done,
        .status, .bus_busy, .evt_start, .evt_stop, .evt_nack, .evt_al, .evt_timeout, .err_evt,
        .addr_strap_low, .addr_strap_high, .scl_sense, .scl_drv(), .scl_oe, .sda_sense,
        .sda_drv(), .sda_oe);
    imes_eeprom_model i_mem (.scl(scl_sense), .sda(sda_sense), .stretch_ns,
        .scl_pull(m_scl), .sda_pull(m_sda));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(logic [7:0] got, logic [7:0] exp, string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic run(string nm, imes_op_e op, logic [15:0] ad, logic [7:0] n, imes_st_e st);
        int k;
        k = 0;
        cmd_op <= op;
        cmd_mem_addr <= ad;
        cmd_count <= n;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1 check(8'(status), 8'(ST_BUSY), "busy");
        while (xfer_done !== 1'b1 && k < 60000) begin
            @(posedge sys_clk);
            #1 k++;
        end
        check(8'(xfer_done), 8'h01, "done");
        repeat (2) @(posedge sys_clk);
        #1 check(8'(status), 8'(st), "status");
        $display("test %s done", nm);
    endtask : run

    // Refusal may land on either of the two edges after the request
    task automatic refuse(string nm, imes_op_e op, logic [7:0] n);
        logic seen;
        cmd_op <= op;
        cmd_count <= n;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1 seen = cmd_refused;
        @(posedge sys_clk);
        #1 seen = seen | cmd_refused;
        check(8'(seen), 8'h01, "refused");
        check(8'(status === ST_BUSY), 8'h00, "not started");
        $display("test %s done", nm);
    endtask : refuse

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Write source with random stalls, output monitor
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
        else if (!tx_valid && tx_q.size() > 0 && $urandom_range(3) == 0) begin
            tx_data <= tx_q.pop_front();
            tx_valid <= 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (nrst && |{err_evt, evt_start, evt_stop, evt_nack, evt_al, evt_timeout})
            check(8'(err_evt), 8'(|{evt_start, evt_stop, evt_nack, evt_al, evt_timeout}), "err");
        if (nrst && evt_nack === 1'b1)
            n_nack++;
        if (nrst && evt_timeout === 1'b1)
            n_to++;
        if (nrst && rx_valid === 1'b1)
            check(rx_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_data, "rx byte");
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        a = 16'($urandom(14874));
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        tx_q = {d0, d1};
        run("write", OP_WRITE, a, 8'h02, ST_IDLE);
        run("poll busy", OP_POLL, a, 8'h00, ST_NACK);
        check(8'(n_nack), 8'h01, "nack event");
        run("poll done", OP_POLL, a, 8'h00, ST_IDLE);
        run("locate", OP_WRITE, a, 8'h00, ST_IDLE);
        exp_q = {d0, d1};
        stretch_ns = 2000;
        run("read", OP_READ, a, 8'h02, ST_IDLE);
        stretch_ns = 0;
        check(8'(exp_q.size()), 8'h00, "read count");
        refuse("read zero", OP_READ, 8'h00);
        tb_sda_low <= 1'b1;
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check(8'(bus_busy), 8'h00, "frozen");
        clk_en <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check(8'(bus_busy), 8'h01, "bus busy");
        refuse("bus busy", OP_WRITE, 8'h01);
        tb_sda_low <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check(8'(bus_busy), 8'h00, "bus free");
        tx_q = {d1};
        fork
            run("timeout", OP_WRITE, a, 8'h01, ST_FAIL);
            begin
                repeat (3000) @(posedge sys_clk);
                tb_scl_low <= 1'b1;
                repeat (1600) @(posedge sys_clk);
                tb_scl_low <= 1'b0;
            end
        join
        check(8'(n_to), 8'h01, "timeout event");
        complete_run();
    end
endmodule : imes_top_bench
